// ---- core/cmx_select.sv ----
/*
  Comparator-1 input selection register with switch-select decode.
  Assumes a single-cycle special-function write/read port from the core
  and a package-size strap pin.
*/
`timescale 1ns/100ps
`default_nettype none
module cmx_select (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_page_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic large_pkg_i,
  output logic [7:0] sfr_rdata_o,
  output logic sfr_hit_o,
  output logic [cmx_pkg::CMX_SW_N-1:0] neg_sw_o,
  output logic [cmx_pkg::CMX_SW_N-1:0] pos_sw_o
);
  import cmx_pkg::*;
  logic [7:0] sel_ff;
  logic [7:0] rdata_ff;
  logic hit_ff;
  logic [2:0] pkg_sync_ff;
  logic pkg_ff;
  logic [CMX_SW_N-1:0] neg_ff;
  logic [CMX_SW_N-1:0] pos_ff;
  wire logic addr_hit;
  wire logic wr_hit;
  wire logic rd_hit;
  wire logic pkg_agree;
  wire logic [7:0] nxt_sel;
  wire logic [7:0] nxt_rdata;
  wire logic nxt_hit;
  wire logic [CMX_SW_N-1:0] nxt_neg;
  wire logic [CMX_SW_N-1:0] nxt_pos;

  assign addr_hit = (sfr_addr_i == CMX_SEL_ADDR) &&
                    (sfr_page_i == CMX_SEL_PAGE);
  assign wr_hit = sfr_wr_i && addr_hit;
  assign rd_hit = sfr_rd_i && addr_hit;
  assign nxt_sel = wr_hit ? sfr_wdata_i : sel_ff;
  // Read in the cycle of a write returns the old value
  assign nxt_rdata = rd_hit ? sel_ff : 8'h00;
  assign nxt_hit = rd_hit || wr_hit;
  assign pkg_agree = (pkg_sync_ff[2] == pkg_sync_ff[1]);

  // Strap through three stages; change taken when last two agree
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pkg_sync_ff <= 3'h0;
      pkg_ff <= 1'b0;
    end else begin
      pkg_sync_ff <= {pkg_sync_ff[1:0], large_pkg_i};
      if (pkg_agree) begin
        pkg_ff <= pkg_sync_ff[2];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_ff <= CMX_SEL_RESET;
    end else begin
      sel_ff <= nxt_sel;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hit_ff <= 1'b0;
    end else begin
      hit_ff <= nxt_hit;
    end
  end

  cmx_decode u_neg (
    .code_i(sel_ff[CMX_NEG_MSB:CMX_NEG_LSB]),
    .large_pkg_i(pkg_ff),
    .onehot_o(nxt_neg)
  );

  cmx_decode u_pos (
    .code_i(sel_ff[CMX_POS_MSB:CMX_POS_LSB]),
    .large_pkg_i(pkg_ff),
    .onehot_o(nxt_pos)
  );

  // Switch selects registered from the stored fields
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      neg_ff <= 12'h000;
    end else begin
      neg_ff <= nxt_neg;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pos_ff <= 12'h000;
    end else begin
      pos_ff <= nxt_pos;
    end
  end

  assign sfr_rdata_o = rdata_ff;
  assign sfr_hit_o = hit_ff;
  assign neg_sw_o = neg_ff;
  assign pos_sw_o = pos_ff;

  // One field code carried by a register write
  sequence s_neg_write(logic [3:0] c);
    wr_hit && (sfr_wdata_i[CMX_NEG_MSB:CMX_NEG_LSB] == c);
  endsequence

  sequence s_pos_write(logic [3:0] c);
    wr_hit && (sfr_wdata_i[CMX_POS_MSB:CMX_POS_LSB] == c);
  endsequence

  a_write_stores: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    wr_hit |=> sel_ff == $past(sfr_wdata_i))
    else $error("write not stored");

  a_hold_value: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !wr_hit |=> $stable(sel_ff))
    else $error("register changed without write");

  a_read_back: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (sfr_rd_i && addr_hit) |=> sfr_rdata_o == $past(sel_ff))
    else $error("read data wrong");

  a_read_idle: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !(sfr_rd_i && addr_hit) |=> sfr_rdata_o == 8'h00)
    else $error("read data not zero without read");

  a_hit_flag: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (sfr_rd_i || sfr_wr_i) |=> sfr_hit_o == $past(addr_hit))
    else $error("hit flag does not match address");

  a_hit_idle: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !(sfr_rd_i || sfr_wr_i) |=> !sfr_hit_o)
    else $error("hit flag without access");

  a_neg_onehot: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    $onehot0(neg_sw_o))
    else $error("negative switches not one-hot");

  a_pos_onehot: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    $onehot0(pos_sw_o))
    else $error("positive switches not one-hot");

  a_neg_first: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    s_neg_write(4'h0) |=> ##1 neg_sw_o == 12'h001)
    else $error("negative code 0 not pin 0");

  a_neg_mid: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    s_neg_write(4'h3) |=> ##1 neg_sw_o == 12'h008)
    else $error("negative code 3 wrong");

  a_neg_p2: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    s_neg_write(4'h8) |=> ##1 neg_sw_o == 12'h100)
    else $error("negative code 8 wrong");

  a_pos_first: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    s_pos_write(4'h0) |=> ##1 pos_sw_o == 12'h001)
    else $error("positive code 0 not pin 0");

  a_pos_p2: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    s_pos_write(4'h8) |=> ##1 pos_sw_o == 12'h100)
    else $error("positive code 8 wrong");

  a_none_high: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    s_neg_write(4'hC) |=> ##1 neg_sw_o == 12'h000)
    else $error("top codes connect a pin");

  a_pos_none: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    s_pos_write(4'hF) |=> ##1 pos_sw_o == 12'h000)
    else $error("positive top code connects a pin");

  // Package as seen when the switch decode is registered
  a_neg_large: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    s_neg_write(4'hB) ##1 pkg_ff |=> neg_sw_o == 12'h800)
    else $error("negative code B wrong on large package");

  a_neg_small: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    s_neg_write(4'h9) ##1 !pkg_ff |=> neg_sw_o == 12'h000)
    else $error("negative code 9 on small package");

  a_pos_large: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    s_pos_write(4'hB) ##1 pkg_ff |=> pos_sw_o == 12'h800)
    else $error("positive code B wrong on large package");

  a_pos_small: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    s_pos_write(4'h9) ##1 !pkg_ff |=> pos_sw_o == 12'h000)
    else $error("positive code 9 on small package");

  a_pkg_agree: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    $changed(pkg_ff) |->
    $past(pkg_agree) && (pkg_ff == $past(pkg_sync_ff[2])))
    else $error("strap taken before it settled");
endmodule
`default_nettype wire

// ---- shared/cmx_pkg.sv ----
/*
  Package for the comparator-1 input selection block: register address,
  field layout, reset value and pin-select widths.
  Assumes the core's special-function bus presents 8-bit address and page.
*/
`default_nettype none
package cmx_pkg;
  localparam logic [7:0] CMX_SEL_ADDR = 8'h9F;
  localparam logic [7:0] CMX_SEL_PAGE = 8'h00;
  localparam logic [7:0] CMX_SEL_RESET = 8'h77;
  localparam int CMX_NEG_MSB = 7;
  localparam int CMX_NEG_LSB = 4;
  localparam int CMX_POS_MSB = 3;
  localparam int CMX_POS_LSB = 0;
  localparam int CMX_SW_N = 12;
  localparam logic [3:0] CMX_LAST_SMALL = 4'h8;
  localparam logic [3:0] CMX_LAST_LARGE = 4'hB;
endpackage
`default_nettype wire

// ---- core/cmx_decode.sv ----
/*
  Decoder from a 4-bit input choice to one-hot pin switch selects.
  Assumes a package-size strap that is stable while in use.
*/
`timescale 1ns/100ps
`default_nettype none
module cmx_decode (
  input wire logic [3:0] code_i,
  input wire logic large_pkg_i,
  output logic [cmx_pkg::CMX_SW_N-1:0] onehot_o
);
  import cmx_pkg::*;
  wire logic [3:0] last_code;
  wire logic code_ok;
  assign last_code = large_pkg_i ? CMX_LAST_LARGE : CMX_LAST_SMALL;
  // Codes above the last valid one connect nothing
  assign code_ok = (code_i <= last_code);
  assign onehot_o = code_ok ? (12'h001 << code_i) : 12'h000;
endmodule
`default_nettype wire

// ---- testbench/comparator1_input_mux_select_tb.sv ----
/*
  Self-checking bench for the comparator-1 input selection register.
  Assumes the single-cycle special-function port and strap of cmx_select.
*/
`timescale 1ns/100ps
`default_nettype none
module comparator1_input_mux_select_tb;
  import cmx_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sfr_wr_i = 1'b0;
  logic sfr_rd_i = 1'b0;
  logic large_pkg_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00;
  logic [7:0] sfr_page_i = 8'h00;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic [7:0] sfr_rdata_o;
  logic sfr_hit_o;
  logic [CMX_SW_N-1:0] neg_sw_o;
  logic [CMX_SW_N-1:0] pos_sw_o;
  int fails = 0;
  int comparisons = 0;
  cmx_select cmx_select_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .sfr_addr_i(sfr_addr_i), .sfr_page_i(sfr_page_i), .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
    .large_pkg_i(large_pkg_i), .sfr_rdata_o(sfr_rdata_o),
    .sfr_hit_o(sfr_hit_o), .neg_sw_o(neg_sw_o), .pos_sw_o(pos_sw_o));
  initial forever #50 clk_i = ~clk_i;
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [11:0] hot(input logic [3:0] c, input logic lg);
    return (c <= 4'h8 || (lg && c <= 4'hB)) ? 12'h001 << c : 12'h000;
  endfunction
  // One strobed access, strobes dropped at the next falling edge
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] pg,
                     input logic [7:0] d);
    @(negedge clk_i);
    sfr_wr_i = wr;
    sfr_rd_i = !wr;
    sfr_addr_i = a;
    sfr_page_i = pg;
    sfr_wdata_i = d;
    @(negedge clk_i);
    sfr_wr_i = 1'b0;
    sfr_rd_i = 1'b0;
  endtask
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] pg,
                           input logic [7:0] d);
    acc(1'b1, a, pg, d);
  endtask
  task automatic sfr_read(input logic [7:0] a, input logic [7:0] pg);
    acc(1'b0, a, pg, 8'h00);
  endtask
  task automatic close_out;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #2000000;
    fails++;
    close_out;
  end
  initial begin
    logic [3:0] n;
    logic [3:0] q;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i) rst_n_i = 1'b1;
    sfr_read(CMX_SEL_ADDR, CMX_SEL_PAGE);
    chk({4'h0, sfr_rdata_o}, {4'h0, CMX_SEL_RESET});
    chk({11'h000, sfr_hit_o}, 12'h001);
    chk(neg_sw_o, 12'h080);
    chk(pos_sw_o, 12'h080);
    for (int p = 0; p < 2; p++) begin
      @(negedge clk_i) large_pkg_i = p[0];
      repeat (6) @(negedge clk_i);
      for (int c = 0; c < 16; c++) begin
        n = c[3:0];
        q = ~n;
        sfr_write(CMX_SEL_ADDR, CMX_SEL_PAGE, {n, q});
        chk({11'h000, sfr_hit_o}, 12'h001);
        @(negedge clk_i);
        chk(neg_sw_o, hot(n, p[0]));
        chk(pos_sw_o, hot(q, p[0]));
        sfr_read(CMX_SEL_ADDR, CMX_SEL_PAGE);
        chk({4'h0, sfr_rdata_o}, {4'h0, n, q});
        chk({11'h000, sfr_hit_o}, 12'h001);
        @(negedge clk_i);
        chk({4'h0, sfr_rdata_o}, 12'h000);
        chk({11'h000, sfr_hit_o}, 12'h000);
      end
    end
    sfr_write(8'h9E, CMX_SEL_PAGE, 8'h12);
    chk({11'h000, sfr_hit_o}, 12'h000);
    sfr_write(CMX_SEL_ADDR, 8'h01, 8'h34);
    chk({11'h000, sfr_hit_o}, 12'h000);
    sfr_read(8'hA0, CMX_SEL_PAGE);
    chk({4'h0, sfr_rdata_o}, 12'h000);
    chk({11'h000, sfr_hit_o}, 12'h000);
    sfr_read(CMX_SEL_ADDR, CMX_SEL_PAGE);
    chk({4'h0, sfr_rdata_o}, 12'h0F0);
    chk(neg_sw_o, 12'h000);
    chk(pos_sw_o, 12'h001);
    close_out;
  end
endmodule
`default_nettype wire
